// ### delay_locked_clock_loop.sv
// delay-locked clock loop: delay tracking, lock, phase, double and divide outputs
// Functional notes
// RULE_01: compare feedback with source, shift delay to cancel
// RULE_02: drive at most two same-edge global nets
// RULE_03: source comes from global buffer or pad
// RULE_04: feedback only from zero-phase or doubled output
// RULE_05: external feedback loop uses doubled output then
// RULE_06: four 1x phases at 0/25/50/75 percent
// RULE_07: high-frequency variant: half phase only, no doubled
// RULE_08: duty correction on gives equal high, low
// RULE_09: duty correction off copies source duty cycle
// RULE_10: locked doubled output is twice source, balanced
// RULE_11: before lock doubled output is 25 percent high
// RULE_12: divided output uses selected factor 1.5 to 16
// RULE_13: divided output always has balanced duty cycle
// RULE_14: loop reset drops lock within four source cycles
// RULE_15: loop reset active high, dynamic or tied low
// RULE_16: loop reset returns delay taps to zero
// RULE_17: lock only after alignment held many source cycles
// RULE_18: users ignore output clocks until lock
// RULE_19: wait option holds configuration done until lock
// RULE_20: simple macro: one output, no reset, lock, multiply
// RULE_21: fourfold clock needs two chained doubling loops
// RULE_22: large source period change requires loop reset
// RULE_23: lock registered, held low during loop reset
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "dll_defines.svh"
module delay_locked_clock_loop
  import dll_pkg::*;
#(
  parameter loop_variant_t    VARIANT      = VAR_FULL,
  parameter logic [`LCW-1:0] LOCK_PERIODS = `LOCK_PERIODS_DEF
)
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic [`AW-1:0] s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output      logic           s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output      logic           s_axi_wready,
  output      logic [1:0]     s_axi_bresp,
  output      logic           s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [`AW-1:0] s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output      logic           s_axi_arready,
  output      logic [31:0]    s_axi_rdata,
  output      logic [1:0]     s_axi_rresp,
  output      logic           s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic           source_clock_input,
  input  wire logic           feedback_clock_input,
  input  wire logic           loop_reset,
  output      logic           phase_zero_out,
  output      logic           phase_quarter_out,
  output      logic           phase_half_out,
  output      logic           phase_three_quarter_out,
  output      logic           doubled_clock_out,
  output      logic           divided_clock_out,
  output      logic [1:0]     global_net_out,
  output      logic           lock_out,
  output      logic           config_done
);
  logic [`SYNC_N-1:0] pins_lvl;
  logic [31:0]        ctrl;
  logic [31:0]        status_w;
  logic [31:0]        period_w;
  loop_reg_t          q;
  loop_reg_t          d;
  logic               src_rise;
  logic               src_fall;
  logic               fb_rise;
  logic               lrst;
  logic               dcc;
  logic               run;
  logic [`PW-1:0]     pos;
  logic [`PW-1:0]     half;
  logic [`PW-1:0]     quarter;
  logic [`PW-1:0]     len1x;
  logic [`PW-1:0]     now_cnt;
  logic [`PW-1:0]     dpos;
  logic [`DW-1:0]     dv_per;
  logic [`DW-1:0]     dv_half;
  logic [`DW-1:0]     dv_nxt;

  pin_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({loop_reset, feedback_clock_input, source_clock_input}),
    .pin_lvl (pins_lvl)
  );

  dll_regs u_regs (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ctrl_q        (ctrl),
    .status_in     (status_w),
    .period_in     (period_w)
  );

  function automatic logic [`PW-1:0] wrap_sub(input logic [`PW-1:0] a,
                                              input logic [`PW-1:0] b,
                                              input logic [`PW-1:0] p);
    return (a >= b) ? a - b : a + p - b;
  endfunction : wrap_sub

  // divide factor in half steps: 1.5, 2, 2.5, 3, 4, 5, 8, 16
  function automatic logic [5:0] div_halves(input logic [2:0] c);
    case (c)
      3'h0:    return 6'h03;
      3'h1:    return 6'h04;
      3'h2:    return 6'h05;
      3'h3:    return 6'h06;
      3'h4:    return 6'h08;
      3'h5:    return 6'h0a;
      3'h6:    return 6'h10;
      default: return 6'h20;
    endcase
  endfunction : div_halves

  function automatic logic net_pick(input logic [1:0] s, input loop_reg_t n);
    case (s)
      2'h0:    return n.ph[0];
      2'h1:    return n.dbl;
      2'h2:    return n.dv;
      default: return n.ph[2];
    endcase
  endfunction : net_pick

  assign src_rise = pins_lvl[`PIN_SRC] & ~q.src_prev;
  assign src_fall = ~pins_lvl[`PIN_SRC] & q.src_prev;
  assign fb_rise  = pins_lvl[`PIN_FB] & ~q.fb_prev;
  assign lrst     = (VARIANT != VAR_SIMPLE) && (pins_lvl[`PIN_RST] || ctrl[`CTRL_SRST]);
  assign dcc      = ctrl[`CTRL_DCC];
  assign run      = (q.st == ST_TRACK) || (q.st == ST_LOCKED);
  assign half     = q.per >> 1;
  assign quarter  = q.per >> 2;
  assign now_cnt  = src_rise ? '0 : q.cnt + 1'b1;
  assign pos      = wrap_sub(q.cnt, q.tap, q.per);
  assign dpos     = (pos >= half) ? pos - half : pos;
  assign len1x    = dcc ? half : q.hi; // see RULE_08 see RULE_09
  assign dv_per   = (`DW'(div_halves(ctrl[`CTRL_DIV_HI:`CTRL_DIV_LO])) * `DW'(q.per)) >> 1;
  assign dv_half  = dv_per >> 1;
  assign dv_nxt   = q.dv_cnt + 1'b1;

  always_comb
  begin
    d          = q;
    d.src_prev = pins_lvl[`PIN_SRC];
    d.fb_prev  = pins_lvl[`PIN_FB];
    d.cnt      = now_cnt;
    if (src_fall)
      d.hi = now_cnt;
    if (fb_rise)
    begin
      d.fb_seen = 1'b1;
      d.fb_pos  = now_cnt;
    end
    if (src_rise)
    begin
      d.fb_seen = 1'b0;
      case (q.st)
        ST_HOLD:    d.st = ST_MEASURE;
        ST_MEASURE:
        begin
          d.per = q.cnt + 1'b1;
          d.st  = ST_TRACK;
        end
        ST_TRACK, ST_LOCKED:
        begin
          d.per = q.cnt + 1'b1;
          if (fb_rise)
          begin
            if (q.align == LOCK_PERIODS - 1'b1)
            begin
              d.locked = 1'b1; // see RULE_17
              d.st     = ST_LOCKED;
            end
            else
              d.align = q.align + 1'b1;
          end
          else if (q.fb_seen)
          begin
            d.align = '0;
            // feedback late: pull output earlier, else push later
            if (q.fb_pos < half)
              d.tap = (q.tap == '0) ? d.per - 1'b1 : q.tap - 1'b1; // see RULE_01
            else
              d.tap = q.tap + 1'b1; // see RULE_01
          end
          if (d.tap >= d.per)
            d.tap = '0;
        end
        default: d.st = ST_HOLD;
      endcase
    end
    if (lrst)
    begin
      d.st      = ST_HOLD;
      d.tap     = '0; // see RULE_16
      d.locked  = 1'b0; // see RULE_14 see RULE_23
      d.align   = '0;
      d.fb_seen = 1'b0;
      d.dv_cnt  = '0;
    end
    else
      d.dv_cnt = (dv_nxt >= dv_per) ? '0 : dv_nxt;
    for (int k = 0; k < 4; k++)
      d.ph[k] = run && (wrap_sub(pos, `PW'(k) * quarter + ((k == 3) ? `PW'(q.per[1]) : '0),
                                 q.per) < len1x); // see RULE_06
    if (VARIANT != VAR_FULL)
    begin
      d.ph[1] = 1'b0; // see RULE_07
      d.ph[3] = 1'b0;
    end
    if (VARIANT == VAR_SIMPLE)
      d.ph[2] = 1'b0; // see RULE_20
    // before lock: one pulse per source period, quarter high
    d.dbl = run && (VARIANT == VAR_FULL) &&
            (q.locked ? (dpos < quarter) : (pos < quarter)); // see RULE_10 see RULE_11
    d.dv  = run && (VARIANT == VAR_FULL) && (q.dv_cnt < dv_half); // see RULE_12 see RULE_13
    d.gnet[0] = net_pick(ctrl[`CTRL_NET0_LO +: 2], d); // see RULE_02
    d.gnet[1] = (VARIANT != VAR_SIMPLE) && net_pick(ctrl[`CTRL_NET1_LO +: 2], d);
    d.done    = !ctrl[`CTRL_WAIT] || d.locked; // see RULE_19
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign phase_zero_out          = q.ph[0];
  assign phase_quarter_out       = q.ph[1];
  assign phase_half_out          = q.ph[2];
  assign phase_three_quarter_out = q.ph[3];
  assign doubled_clock_out       = q.dbl;
  assign divided_clock_out       = q.dv;
  assign global_net_out          = q.gnet;
  assign lock_out                = (VARIANT == VAR_SIMPLE) ? 1'b0 : q.locked; // see RULE_20
  assign config_done             = q.done;
  assign status_w = {6'h00, q.tap, 12'h000, q.st, q.done, lock_out};
  assign period_w = {6'h00, q.hi, 6'h00, q.per};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_late_feedback;
    q.st == ST_TRACK && src_rise && !fb_rise && q.fb_seen && !lrst &&
    q.fb_pos < half && q.tap != '0 && q.cnt + 1'b1 == q.per;
  endsequence
  sequence s_loop_reset;
    lrst ##1 lrst;
  endsequence

  property p_delay_trim;
    s_late_feedback |=> q.tap == $past(q.tap) - 1'b1;
  endproperty
  a_delay_trim: assert property (p_delay_trim) else $error("tap not trimmed"); // see RULE_01

  property p_lock_drop;
    lrst |=> !lock_out ##1 !lock_out;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock not dropped"); // see RULE_14

  property p_lock_held_low;
    s_loop_reset |-> !q.locked && q.st == ST_HOLD;
  endproperty
  a_lock_held_low: assert property (p_lock_held_low) else $error("lock in reset"); // see RULE_23

  property p_taps_zero;
    lrst |=> q.tap == '0;
  endproperty
  a_taps_zero: assert property (p_taps_zero) else $error("taps not zero"); // see RULE_16

  property p_lock_after_align;
    $rose(q.locked) |-> $past(q.align) == LOCK_PERIODS - 1'b1 && $past(fb_rise);
  endproperty
  a_lock_after_align: assert property (p_lock_after_align) else $error("early lock"); // see RULE_17

  property p_wait_done;
    q.done && !q.locked |-> !$past(ctrl[`CTRL_WAIT]);
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("done before lock"); // see RULE_19

  property p_ph0_balanced;
    run && dcc && half != '0 && pos == '0 |=> q.ph[0];
  endproperty
  a_ph0_balanced: assert property (p_ph0_balanced) else $error("phase 0 rise"); // see RULE_08

  property p_ph0_fall;
    run && dcc && pos == half |=> !q.ph[0];
  endproperty
  a_ph0_fall: assert property (p_ph0_fall) else $error("phase 0 duty"); // see RULE_08

  property p_ph0_raw;
    run && !dcc && pos == q.hi && q.hi < q.per |=> !q.ph[0];
  endproperty
  a_ph0_raw: assert property (p_ph0_raw) else $error("raw duty lost"); // see RULE_09

  property p_quarter_phase;
    VARIANT == VAR_FULL && run && len1x != '0 && pos == quarter |=> q.ph[1];
  endproperty
  a_quarter_phase: assert property (p_quarter_phase) else $error("quarter phase"); // see RULE_06

  property p_hf_outputs;
    VARIANT == VAR_HF |-> !q.dbl && !q.ph[1] && !q.ph[3];
  endproperty
  a_hf_outputs: assert property (p_hf_outputs) else $error("hf extra output"); // see RULE_07

  property p_dbl_locked;
    VARIANT == VAR_FULL && run && q.locked && quarter != '0 && pos == half |=> q.dbl;
  endproperty
  a_dbl_locked: assert property (p_dbl_locked) else $error("doubled missing"); // see RULE_10

  property p_dbl_prelock;
    run && !q.locked && pos == quarter |=> !q.dbl;
  endproperty
  a_dbl_prelock: assert property (p_dbl_prelock) else $error("prelock doubled"); // see RULE_11

  property p_div_wave;
    VARIANT == VAR_FULL && run && !lrst && dv_half != '0 && q.dv_cnt == '0
      |=> q.dv [*1] ##0 (q.dv_cnt == 1);
  endproperty
  a_div_wave: assert property (p_div_wave) else $error("divided rise"); // see RULE_12

  property p_div_half;
    run && q.dv_cnt == dv_half |=> !q.dv;
  endproperty
  a_div_half: assert property (p_div_half) else $error("divided duty"); // see RULE_13

  property p_simple;
    VARIANT == VAR_SIMPLE |-> !lock_out && !q.dbl && !q.dv && !q.ph[2];
  endproperty
  a_simple: assert property (p_simple) else $error("simple macro extra"); // see RULE_20
endmodule : delay_locked_clock_loop

// ### dll_defines.svh
// constants for the delay-locked clock loop: widths, register map, fields
`ifndef DLL_DEFINES_SVH
`define DLL_DEFINES_SVH
`define PW               10
`define DW               16
`define LCW              16
`define AW               8
`define SYNC_N           3
`define PIN_SRC          0
`define PIN_FB           1
`define PIN_RST          2
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_PERIOD       8'h08
`define CTRL_RST         32'h0000_0103
`define CTRL_DCC         0
`define CTRL_DIV_LO      1
`define CTRL_DIV_HI      3
`define CTRL_WAIT        4
`define CTRL_SRST        5
`define CTRL_NET0_LO     6
`define CTRL_NET1_LO     8
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3
`define LOCK_PERIODS_DEF 16'h0800
`endif

// ### dll_pkg.sv
// types shared by the delay-locked clock loop modules
`include "dll_defines.svh"
package dll_pkg;
  typedef enum logic [1:0] {VAR_FULL, VAR_HF, VAR_SIMPLE} loop_variant_t;
  typedef enum logic [1:0] {ST_HOLD, ST_MEASURE, ST_TRACK, ST_LOCKED} loop_state_t;
  typedef struct packed {
    logic [`SYNC_N-1:0] s1;
    logic [`SYNC_N-1:0] s2;
    logic [`SYNC_N-1:0] s3;
    logic [`SYNC_N-1:0] lvl;
  } sync_state_t;
  typedef struct packed {
    logic           aw_have;
    logic           w_have;
    logic [`AW-1:0] aw_addr;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [1:0]     rresp;
    logic [31:0]    rdata;
    logic [31:0]    ctrl;
  } axil_state_t;
  typedef struct packed {
    loop_state_t     st;
    logic            src_prev;
    logic            fb_prev;
    logic            fb_seen;
    logic            locked;
    logic            done;
    logic            dbl;
    logic            dv;
    logic [3:0]      ph;
    logic [1:0]      gnet;
    logic [`PW-1:0]  cnt;
    logic [`PW-1:0]  per;
    logic [`PW-1:0]  hi;
    logic [`PW-1:0]  tap;
    logic [`PW-1:0]  fb_pos;
    logic [`LCW-1:0] align;
    logic [`DW-1:0]  dv_cnt;
  } loop_reg_t;
endpackage : dll_pkg

// ### pin_sync.sv
// three-stage synchroniser for the loop's pin inputs
`timescale 1ns/1ns
`include "dll_defines.svh"
module pin_sync
  import dll_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [`SYNC_N-1:0] pin_in,
  output      logic [`SYNC_N-1:0] pin_lvl
);
  sync_state_t s_q;
  sync_state_t s_d;

  always_comb
  begin
    s_d     = s_q;
    s_d.s1  = pin_in;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    // level moves only where stages two and three agree
    s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 ^ s_q.s3));
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pin_lvl = s_q.lvl;
endmodule : pin_sync

// ### dll_regs.sv
// axi4-lite register slave for the delay-locked clock loop
`timescale 1ns/1ns
`include "dll_defines.svh"
module dll_regs
  import dll_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic [`AW-1:0] s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output      logic           s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output      logic           s_axi_wready,
  output      logic [1:0]     s_axi_bresp,
  output      logic           s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [`AW-1:0] s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output      logic           s_axi_arready,
  output      logic [31:0]    s_axi_rdata,
  output      logic [1:0]     s_axi_rresp,
  output      logic           s_axi_rvalid,
  input  wire logic           s_axi_rready,
  output      logic [31:0]    ctrl_q,
  input  wire logic [31:0]    status_in,
  input  wire logic [31:0]    period_in
);
  axil_state_t r_q;
  axil_state_t r_d;

  // 0 ctrl, 1 status, 2 period, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [`AW-1:0] a);
    logic [`AW-1:0] w;
    w = {a[`AW-1:2], 2'h0};
    if (w == `REG_CTRL)
      return 2'h0;
    else if (w == `REG_STATUS)
      return 2'h1;
    else if (w == `REG_PERIOD)
      return 2'h2;
    return 2'h3;
  endfunction : reg_sel

  assign s_axi_awready = !r_q.aw_have && !r_q.bvalid;
  assign s_axi_wready  = !r_q.w_have && !r_q.bvalid;
  assign s_axi_arready = !r_q.rvalid;

  always_comb
  begin
    r_d = r_q;
    if (r_q.bvalid && s_axi_bready)
      r_d.bvalid = 1'b0;
    if (r_q.rvalid && s_axi_rready)
      r_d.rvalid = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      r_d.aw_have = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      r_d.w_have = 1'b1;
      r_d.wdata  = s_axi_wdata;
      r_d.wstrb  = s_axi_wstrb;
    end
    if (r_d.aw_have && r_d.w_have)
    begin
      r_d.aw_have = 1'b0;
      r_d.w_have  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = `RESP_OKAY;
      case (reg_sel(r_d.aw_addr))
        2'h0:
          for (int b = 0; b < 4; b++)
            if (r_d.wstrb[b])
              r_d.ctrl[8*b +: 8] = r_d.wdata[8*b +: 8];
        2'h1, 2'h2: ;
        default: r_d.bresp = `RESP_DECERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = `RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        2'h0: r_d.rdata = r_q.ctrl;
        2'h1: r_d.rdata = status_in;
        2'h2: r_d.rdata = period_in;
        default:
        begin
          r_d.rdata = 32'h0000_0000;
          r_d.rresp = `RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r_q      <= '0;
      r_q.ctrl <= `CTRL_RST;
    end
    else
      r_q <= r_d;
  end

  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp  = r_q.bresp;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rresp  = r_q.rresp;
  assign s_axi_rdata  = r_q.rdata;
  assign ctrl_q       = r_q.ctrl;
endmodule : dll_regs

// ### far_side_model.sv
// far-side model: source clock generator and board feedback path
`timescale 1ns/1ns
module far_side_model
#(
  parameter int PERIOD = 8,
  parameter int HIGH   = 3
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic phase_zero_out,
  output      logic source_clock_input,
  output      logic feedback_clock_input
);
  int cnt_q;
  // steady source from a dedicated pad, period never changes
  // feedback from the zero-phase output; doubled output stays on chip
  // single loop only, no fourfold clock wanted, so none is chained
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= 0;
      source_clock_input <= 1'b0;
      feedback_clock_input <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      source_clock_input <= (cnt_q < HIGH);
      feedback_clock_input <= phase_zero_out;
    end
  end
endmodule : far_side_model

// ### delay_locked_clock_loop_tb_top.sv
// self-checking bench for the delay-locked clock loop
`timescale 1ns/1ns
`include "dll_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module delay_locked_clock_loop_tb_top;
  localparam int PER = 8;
  localparam int HI  = 3;
  logic           clk = 1'b0, sys_rst = 1'b1, loop_reset = 1'b0;
  logic [`AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]    s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]     s_axi_wstrb = 4'hf;
  logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic           s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]     s_axi_bresp, s_axi_rresp, global_net_out, r;
  logic           source_clock_input, feedback_clock_input, lock_out, config_done;
  logic           phase_zero_out, phase_quarter_out, phase_half_out, phase_three_quarter_out;
  logic           doubled_clock_out, divided_clock_out;
  int             mismatches = 0, comparisons = 0, cycles = 0, p, h;
  int             halves [8] = '{3, 4, 5, 6, 8, 10, 16, 32};
  logic [3:0]     pat [4] = '{4'b1001, 4'b0011, 4'b0110, 4'b1100};
  wire  [7:0]     outs = {global_net_out, divided_clock_out, doubled_clock_out,
                          phase_three_quarter_out, phase_half_out, phase_quarter_out,
                          phase_zero_out};

  delay_locked_clock_loop
  #(
    .LOCK_PERIODS (16'h0004)
  )
  u_delay_locked_clock_loop
  (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .source_clock_input, .feedback_clock_input, .loop_reset,
    .phase_zero_out, .phase_quarter_out, .phase_half_out, .phase_three_quarter_out,
    .doubled_clock_out, .divided_clock_out, .global_net_out, .lock_out, .config_done
  );

  far_side_model
  #(
    .PERIOD (PER),
    .HIGH   (HI)
  )
  u_far_side_model
  (
    .clk, .sys_rst, .phase_zero_out, .source_clock_input, .feedback_clock_input
  );

  always #4 clk = ~clk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // bready stays high between writes
    s_axi_bready <= 1'b1;
    r = 2'bxx;
    forever
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // rready stays high between reads
    s_axi_rready <= 1'b1;
    r = 2'bxx;
    forever
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask : rd

  task automatic wait_lvl(input int b, input logic v);
    repeat (3000)
    begin
      @(posedge clk);
      if (outs[b] === v) break;
    end
  endtask : wait_lvl

  task automatic wait_lock();
    repeat (3000)
    begin
      @(posedge clk);
      if (lock_out === 1'b1) break;
    end
  endtask : wait_lock

  // cycles from one rise to the next, and high cycles in between
  task automatic meas(input int b);
    p = 0;
    h = 0;
    wait_lvl(b, 1'b0);
    wait_lvl(b, 1'b1);
    do
    begin
      h += outs[b];
      p++;
      @(posedge clk);
    end
    while (!(outs[b] === 1'b1 && p > h) && p < 600);
  endtask : meas

  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`REG_CTRL);
    `CHK(d, `CTRL_RST)
    rd(8'h0C);
    `CHK(r, `RESP_DECERR)
    `CHK(d, 32'h0)
    wr(8'h0C, 32'hffff_ffff);
    `CHK(r, `RESP_DECERR)
    `CHK(lock_out, 1'b0)
    wait_lock();
    `CHK(lock_out, 1'b1)
    `CHK(config_done, 1'b1)
    rd(`REG_PERIOD);
    `CHK(d[9:0], 10'(PER))
    $display("test lock done");
    // outputs used only once locked
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      `CHK(outs[3:0], pat[k])
      repeat (2) @(posedge clk);
    end
    meas(0);
    `CHK(h, PER / 2)
    meas(4);
    `CHK(p, PER / 2)
    `CHK(h, PER / 4)
    meas(6);
    `CHK(h, PER / 2)
    meas(7);
    `CHK(p, PER / 2)
    // net0 carries divided, net1 carries half phase
    wr(`REG_CTRL, 32'h0000_0383);
    meas(6);
    `CHK(p, PER * 2)
    meas(7);
    `CHK(p, PER)
    `CHK(h, PER / 2)
    wr(`REG_CTRL, 32'h0000_0102);
    meas(0);
    `CHK(p, PER)
    `CHK(h, HI)
    $display("test phases done");
    for (int c = 0; c < 8; c++)
    begin
      wr(`REG_CTRL, 32'h0000_0101 | (c << 1));
      meas(5);
      `CHK(p, halves[c] * PER / 2)
      `CHK(h, halves[c] * PER / 4)
    end
    $display("test divide done");
    wr(`REG_CTRL, `CTRL_RST);
    loop_reset <= 1'b1;
    repeat (4 * PER) @(posedge clk);
    `CHK(lock_out, 1'b0)
    rd(`REG_STATUS);
    `CHK(d[25:16], 10'h0)
    `CHK(lock_out, 1'b0)
    loop_reset <= 1'b0;
    wait_lvl(4, 1'b1);
    h = 0;
    repeat (PER)
    begin
      h += outs[4];
      @(posedge clk);
    end
    `CHK(h, PER / 4)
    `CHK(lock_out, 1'b0)
    wait_lock();
    `CHK(lock_out, 1'b1)
    $display("test loop reset done");
    wr(`REG_CTRL, 32'h0000_0133);
    repeat (4 * PER) @(posedge clk);
    `CHK(lock_out, 1'b0)
    `CHK(config_done, 1'b0)
    wr(`REG_CTRL, 32'h0000_0113);
    wait_lock();
    `CHK(config_done, 1'b1)
    rd(`REG_STATUS);
    `CHK(d[1:0], 2'b11)
    $display("test wait option done");
    stop_test();
  end
endmodule : delay_locked_clock_loop_tb_top
